// [hw/vlan_tag_regs.svh]
// Constants for the port VLAN tag classifier and rewriter
`ifndef VLAN_TAG_REGS_SVH
`define VLAN_TAG_REGS_SVH

// Tag protocol identifiers
`define ETYPE_CUSTOMER_TAG 16'h8100
`define ETYPE_SERVICE_TAG 16'h88a8
// Reset value of the global custom ethertype
`define CUSTOM_ETYPE_RST 16'h88a8
// Default port VLAN, management VLAN and private VLAN after reset
`define PVID_RST 12'h001
`define MGMT_VID_RST 12'h001
`define DEF_VLAN 12'h001
`define DEF_PVLAN 1
// Buffer depth
`define BUF_DEPTH 2'h2

`endif

// [hw/vlan_tag_pkg.sv]
// Types shared by the port VLAN tag classifier
package vlan_tag_pkg;

    // Per-port VLAN port type
    typedef enum logic [1:0] {
        PT_UNAWARE = 2'b00,
        PT_CUSTOMER = 2'b01,
        PT_SERVICE = 2'b10,
        PT_SERVICE_CUSTOM = 2'b11
    } port_type_t;

    // Egress tagging behaviour
    typedef enum logic [1:0] {
        TX_UNTAG_PVID = 2'b00,
        TX_TAG_ALL = 2'b01,
        TX_UNTAG_ALL = 2'b10
    } tx_mode_t;

endpackage

// [hw/vlan_port_tag_processing.sv]
// Per-port VLAN tag classification, rewriting and forwarding mask
//
// How it works
// - Untagged frames get port default VLAN tag
// - Unaware port: 0x8100 tagged frame gets double-tagged
// - Unaware/customer ports drop non-0x8100 tagged frames
// - Customer port forwards 0x8100 frames without new tag
// - Service ports drop tagged frames not 0x88A8
// - Customer/unaware egress uses identifier 0x8100
// - Service port egress uses identifier 0x88A8
// - Custom service egress uses global custom ethertype
// - Unaware egress tagging setting still decides tag
// - Private port frames go to uplink only
// - Forward only if in VLAN and private VLAN
// - Reset: unaware, VLAN 1, private VLAN 1
// - Isolated ports talk only to promiscuous ports
// - Promiscuous ports reach private VLAN ports in the classified VLAN
// - Management accepted only from management VLAN members
// - Custom ethertype resets to 0x88a8
// - Ingress filter drops non-member classified VLAN
// - Egress tagging: untag pvid, tag all, untag all
`timescale 1ns/1ns
`include "vlan_tag_regs.svh"

module vlan_port_tag_processing #(
    parameter int NPORTS = 8,
    parameter int NPV = 8,
    parameter int VID_BITS = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Per-port configuration write
    input wire logic cfg_port_we,
    input wire logic [$clog2(NPORTS)-1:0] cfg_port_idx,
    input wire vlan_tag_pkg::port_type_t cfg_port_type,
    input wire vlan_tag_pkg::tx_mode_t cfg_tx_mode,
    input wire logic [11:0] cfg_pvid,
    input wire logic cfg_filter_en,
    input wire logic cfg_isolate_en,
    input wire logic cfg_private_en,
    // Global configuration write
    input wire logic cfg_glob_we,
    input wire logic [15:0] cfg_custom_etype,
    input wire logic [11:0] cfg_mgmt_vid,
    // VLAN membership table write
    input wire logic cfg_vlan_we,
    input wire logic [VID_BITS-1:0] cfg_vlan_vid,
    input wire logic [NPORTS-1:0] cfg_vlan_members,
    // Private VLAN table write
    input wire logic cfg_pvlan_we,
    input wire logic [$clog2(NPV)-1:0] cfg_pvlan_idx,
    input wire logic [NPORTS-1:0] cfg_pvlan_members,
    input wire logic [$clog2(NPORTS)-1:0] cfg_pvlan_uplink,
    // Frame header descriptor in
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [$clog2(NPORTS)-1:0] in_port,
    input wire logic in_tagged,
    input wire logic [15:0] in_tag_protocol_identifier,
    input wire logic [11:0] in_vid,
    input wire logic in_mgmt,
    // Forwarding decision out
    output logic out_valid,
    input wire logic out_ready,
    output logic out_drop,
    output logic out_mgmt_ok,
    output logic out_push_tag,
    output logic out_keep_inner,
    output logic [11:0] out_vid,
    output logic [NPORTS-1:0] out_port_mask,
    output logic [NPORTS-1:0] out_tx_tagged,
    output logic [NPORTS-1:0][15:0] out_tx_tag_protocol_identifier
);
    import vlan_tag_pkg::*;

    localparam int PW = $clog2(NPORTS);
    localparam int PVW = $clog2(NPV);
    localparam int VIDS = 1 << VID_BITS;

    typedef struct packed {
        port_type_t ptype;
        tx_mode_t txm;
        logic [11:0] pvid;
        logic filt;
        logic iso;
        logic priv;
    } pcfg_t;

    typedef struct packed {
        logic drop;
        logic mgmt_ok;
        logic push;
        logic keep_inner;
        logic [11:0] vid;
        logic [NPORTS-1:0] mask;
        logic [NPORTS-1:0] tx_tag;
        logic [NPORTS-1:0][15:0] tx_tag_protocol_identifier;
    } res_t;

    typedef struct packed {
        pcfg_t [NPORTS-1:0] pc;
        logic [15:0] etype;
        logic [11:0] mgmt_vid;
        res_t [1:0] slot;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } state_t;

    state_t s_q, s_d;

    // Membership tables
    logic [NPORTS-1:0] vlan_mem_q [0:VIDS-1];
    logic [NPORTS-1:0] pvlan_mem_q [0:NPV-1];
    logic [PW-1:0] pvlan_up_q [0:NPV-1];

    // Egress tag protocol identifier by port type
    function automatic logic [15:0] egress_identifier(port_type_t pt, logic [15:0] etype);
        logic [15:0] t;
        t = `ETYPE_CUSTOMER_TAG;
        unique case (pt)
            PT_UNAWARE, PT_CUSTOMER: t = `ETYPE_CUSTOMER_TAG;
            PT_SERVICE: t = `ETYPE_SERVICE_TAG;
            PT_SERVICE_CUSTOM: t = etype;
        endcase
        return t;
    endfunction

    // VLAN membership lookup
    function automatic logic [NPORTS-1:0] vlan_members(logic [11:0] vid);
        return vlan_mem_q[vid[VID_BITS-1:0]];
    endfunction

    // Classification of the incoming descriptor
    pcfg_t src;
    logic cls_drop;
    logic cls_push;
    logic [11:0] cls_vid;
    logic pv_found;
    logic [PVW-1:0] pv_idx;
    logic [NPORTS-1:0] iso_all;
    logic [NPORTS-1:0] fwd_mask;
    res_t res;
    // Member sets of the classified and management VLANs
    logic [NPORTS-1:0] cls_members;
    logic [NPORTS-1:0] mgmt_members;

    always_comb begin
        src = s_q.pc[in_port];
        cls_drop = 1'b0;
        cls_push = 1'b0;
        cls_vid = src.pvid;
        if (!in_tagged) begin
            cls_push = 1'b1;
        end else begin
            // Tagged frame: port type picks accept, push or drop
            unique case (src.ptype)
                PT_UNAWARE: begin
                    cls_push = (in_tag_protocol_identifier == `ETYPE_CUSTOMER_TAG);
                    cls_drop = (in_tag_protocol_identifier != `ETYPE_CUSTOMER_TAG);
                end
                PT_CUSTOMER: begin
                    // forward as is, classified by its tag
                    cls_vid = in_vid;
                    cls_drop = (in_tag_protocol_identifier != `ETYPE_CUSTOMER_TAG);
                end
                PT_SERVICE, PT_SERVICE_CUSTOM: begin
                    cls_vid = in_vid;
                    cls_drop = (in_tag_protocol_identifier != `ETYPE_SERVICE_TAG);
                end
            endcase
        end
    end

    // Private VLAN of the source and isolated port set
    always_comb begin
        pv_found = 1'b0;
        pv_idx = '0;
        // Lowest index wins for a port in several
        for (int i = NPV - 1; i >= 0; i--) begin
            if (pvlan_mem_q[i][in_port]) begin
                pv_found = 1'b1;
                pv_idx = PVW'(i);
            end
        end
        for (int p = 0; p < NPORTS; p++) begin
            iso_all[p] = s_q.pc[p].iso;
        end
    end

    // Forwarding mask and egress tagging
    always_comb begin
        res = '0;
        // Both member sets looked up once per descriptor
        cls_members = vlan_members(cls_vid);
        mgmt_members = vlan_members(s_q.mgmt_vid);
        // promiscuous source reaches private VLAN members that are also in the classified VLAN
        fwd_mask = cls_members & pvlan_mem_q[pv_idx];
        fwd_mask[in_port] = 1'b0;
        // isolated source only towards promiscuous ports
        if (src.iso) begin
            fwd_mask = fwd_mask & ~iso_all;
        end
        // private port goes to its uplink only
        // Uplink wins even if it is the source itself
        if (src.priv) begin
            fwd_mask = '0;
            fwd_mask[pvlan_up_q[pv_idx]] = 1'b1;
        end
        res.vid = cls_vid;
        res.push = cls_push;
        // new tag is outer, inner kept
        res.keep_inner = cls_push & in_tagged;
        res.drop = cls_drop;
        if (src.filt && !cls_members[in_port]) begin
            res.drop = 1'b1;
        end
        // source must be in a VLAN and a private VLAN
        // Filter bit adds nothing beyond this check
        if (!cls_members[in_port] || !pv_found) begin
            res.drop = 1'b1;
        end
        // management only via management VLAN members
        res.mgmt_ok = in_mgmt & ~res.drop & mgmt_members[in_port];
        res.mask = res.drop ? '0 : fwd_mask;
        for (int p = 0; p < NPORTS; p++) begin
            // Egress identifier follows the egress port's own type
            res.tx_tag_protocol_identifier[p] = egress_identifier(s_q.pc[p].ptype, s_q.etype);
            // tagging setting decides the tag on every type
            unique case (s_q.pc[p].txm)
                TX_UNTAG_PVID: res.tx_tag[p] = (cls_vid != s_q.pc[p].pvid);
                TX_TAG_ALL: res.tx_tag[p] = 1'b1;
                TX_UNTAG_ALL: res.tx_tag[p] = 1'b0;
                default: res.tx_tag[p] = 1'b0;
            endcase
        end
    end

    // Handshakes
    // Ready drops only while both slots hold unread results
    assign in_ready = (s_q.cnt != `BUF_DEPTH);
    assign out_valid = (s_q.cnt != 2'h0);

    // Next state: configuration and two-entry buffer
    always_comb begin
        s_d = s_q;
        if (cfg_port_we) begin
            s_d.pc[cfg_port_idx].ptype = cfg_port_type;
            s_d.pc[cfg_port_idx].txm = cfg_tx_mode;
            s_d.pc[cfg_port_idx].pvid = cfg_pvid;
            s_d.pc[cfg_port_idx].filt = cfg_filter_en;
            s_d.pc[cfg_port_idx].iso = cfg_isolate_en;
            s_d.pc[cfg_port_idx].priv = cfg_private_en;
        end
        if (cfg_glob_we) begin
            s_d.etype = cfg_custom_etype;
            s_d.mgmt_vid = cfg_mgmt_vid;
        end
        if (in_valid && in_ready) begin
            s_d.slot[s_q.wp] = res;
            s_d.wp = ~s_q.wp;
        end
        if (out_valid && out_ready) begin
            s_d.rp = ~s_q.rp;
        end
        // Push and pop together leave the count alone
        unique case ({in_valid && in_ready, out_valid && out_ready})
            2'b10: s_d.cnt = s_q.cnt + 2'h1;
            2'b01: s_d.cnt = s_q.cnt - 2'h1;
            default: s_d.cnt = s_q.cnt;
        endcase
        // Reset last, so it overrides a write in the same cycle
        if (!rst_n) begin
            s_d = '0;
            for (int p = 0; p < NPORTS; p++) begin
                s_d.pc[p].ptype = PT_UNAWARE;
                s_d.pc[p].txm = TX_UNTAG_PVID;
                s_d.pc[p].pvid = `PVID_RST;
                s_d.pc[p].iso = 1'b0;
                s_d.pc[p].filt = 1'b0;
                s_d.pc[p].priv = 1'b0;
            end
            s_d.etype = `CUSTOM_ETYPE_RST;
            s_d.mgmt_vid = `MGMT_VID_RST;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    // Membership tables
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // all ports in VLAN 1 and private VLAN 1
            // Every VLAN but the default starts empty
            for (int v = 0; v < VIDS; v++) begin
                vlan_mem_q[v] <= (v == int'(`DEF_VLAN)) ? '1 : '0;
            end
            // Private VLAN 1 holds all ports, uplinks at port 0
            for (int i = 0; i < NPV; i++) begin
                pvlan_mem_q[i] <= (i == `DEF_PVLAN) ? '1 : '0;
                pvlan_up_q[i] <= '0;
            end
        end else begin
            if (cfg_vlan_we) begin
                vlan_mem_q[cfg_vlan_vid] <= cfg_vlan_members;
            end
            if (cfg_pvlan_we) begin
                pvlan_mem_q[cfg_pvlan_idx] <= cfg_pvlan_members;
                pvlan_up_q[cfg_pvlan_idx] <= cfg_pvlan_uplink;
            end
        end
    end

    // Buffer head onto the outputs
    // Oldest slot shown; it holds until taken
    assign out_drop = s_q.slot[s_q.rp].drop;
    assign out_mgmt_ok = s_q.slot[s_q.rp].mgmt_ok;
    assign out_push_tag = s_q.slot[s_q.rp].push;
    assign out_keep_inner = s_q.slot[s_q.rp].keep_inner;
    assign out_vid = s_q.slot[s_q.rp].vid;
    assign out_port_mask = s_q.slot[s_q.rp].mask;
    assign out_tx_tagged = s_q.slot[s_q.rp].tx_tag;
    assign out_tx_tag_protocol_identifier = s_q.slot[s_q.rp].tx_tag_protocol_identifier;

endmodule // vlan_port_tag_processing

// [bench/vlan_tag_props.sv]
// Port checks on the VLAN tag classifier
`timescale 1ns/1ns
module vlan_tag_props #(parameter int NPORTS = 8) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Descriptor in
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic in_tagged,
    // Result out
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic out_drop,
    input wire logic out_mgmt_ok,
    input wire logic out_push_tag,
    input wire logic out_keep_inner,
    input wire logic [11:0] out_vid,
    input wire logic [NPORTS-1:0] out_port_mask
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Handshake, buffering and classification relations
    a_hold_result: assert property (out_valid && !out_ready |=>
        out_valid && $stable(out_vid) && $stable(out_port_mask)) else $error("result moved");
    a_take_answer: assert property (in_valid && in_ready |=> out_valid)
        else $error("no result after accept");
    a_empty_ready: assert property (!out_valid |-> in_ready)
        else $error("empty buffer refused");
    a_reset_empty: assert property (disable iff (1'b0) !rst_n |=> !out_valid)
        else $error("result during reset");
    a_untag_push: assert property (in_valid && in_ready && !out_valid && !in_tagged
        |=> out_drop || out_push_tag) else $error("untagged frame not tagged");
    a_inner_push: assert property (out_valid && out_keep_inner |-> out_push_tag)
        else $error("inner kept without push");
    a_mgmt_pass: assert property (out_valid && out_mgmt_ok |-> !out_drop)
        else $error("management on dropped frame");
    a_drop_mask: assert property (out_valid && out_drop |-> out_port_mask == '0)
        else $error("dropped frame has ports");
    // Main scenarios
    c_double: cover property (out_valid && out_keep_inner);
    c_drop: cover property (out_valid && out_drop);
    c_stall: cover property (out_valid && !out_ready ##1 !in_ready);
endmodule // vlan_tag_props

bind vlan_port_tag_processing vlan_tag_props #(.NPORTS(NPORTS)) u_props (.clk(clk),
    .rst_n(rst_n), .in_valid(in_valid), .in_ready(in_ready), .in_tagged(in_tagged),
    .out_valid(out_valid), .out_ready(out_ready), .out_drop(out_drop),
    .out_mgmt_ok(out_mgmt_ok), .out_push_tag(out_push_tag),
    .out_keep_inner(out_keep_inner), .out_vid(out_vid), .out_port_mask(out_port_mask));

// [bench/result_sink.sv]
// Consumer of forwarding results, prompt or stalling
`timescale 1ns/1ns
module result_sink (
    // Clock and control
    input wire logic clk,
    input wire logic stall,
    // Result handshake
    input wire logic out_valid,
    output logic out_ready
);
    // Ready moves just after each edge
    initial out_ready = 1'b0;
    always @(posedge clk) out_ready <= #1 !stall;
endmodule // result_sink

// [bench/tb_top.sv]
// Self-checking bench for the port VLAN tag classifier
`timescale 1ns/1ns
module tb_top;
    import vlan_tag_pkg::*;
    logic clk, rst_n, stall, out_ready, in_ready, out_valid, out_drop, out_mgmt_ok;
    logic out_push_tag, out_keep_inner, cfg_port_we, cfg_filter_en, cfg_isolate_en;
    logic cfg_private_en, cfg_glob_we, cfg_vlan_we, cfg_pvlan_we, in_valid, in_tagged, in_mgmt;
    logic [2:0] cfg_port_idx, cfg_pvlan_idx, cfg_pvlan_uplink, in_port;
    port_type_t cfg_port_type;
    tx_mode_t cfg_tx_mode;
    logic [11:0] cfg_pvid, cfg_mgmt_vid, cfg_vlan_vid, in_vid, out_vid;
    logic [15:0] cfg_custom_etype, in_tag_protocol_identifier;
    logic [7:0] cfg_vlan_members, cfg_pvlan_members, out_port_mask, out_tx_tagged;
    logic [7:0][15:0] out_tx_tag_protocol_identifier;
    logic [127:0] tp_e;
    logic [159:0] q[$];
    int n_fail, samples_checked;
    // Design and result consumer
    vlan_port_tag_processing dut (.*);
    result_sink sink (.clk(clk), .stall(stall), .out_valid(out_valid), .out_ready(out_ready));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Capture each consumed result
    always @(posedge clk) if (out_valid && out_ready) q.push_back({out_drop, out_mgmt_ok,
        out_push_tag, out_keep_inner, out_vid, out_port_mask, out_tx_tagged,
        out_tx_tag_protocol_identifier});
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [127:0] g, e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic pulse(ref logic we);
        @(posedge clk);
        #1 we = 1'b1;
        @(posedge clk);
        #1 we = 1'b0;
    endtask
    task automatic port(input logic [2:0] i, port_type_t t, tx_mode_t m, logic [1:0] ip);
        cfg_port_idx = i;
        cfg_port_type = t;
        cfg_tx_mode = m;
        {cfg_isolate_en, cfg_private_en} = ip;
        pulse(cfg_port_we);
    endtask
    // Offer one descriptor, held until taken
    task automatic tx(input logic [2:0] p, logic [16:0] tg, logic [11:0] v, logic mg);
        int n;
        @(posedge clk);
        #1 {in_valid, in_port, in_tagged} = {1'b1, p, tg[16]};
        {in_tag_protocol_identifier, in_vid, in_mgmt} = {tg[15:0], v, mg};
        for (n = 0; n < 50 && !in_ready; n++) @(posedge clk) #1;
        if (n == 50) n_fail++;
        if (n == 50) close_out();
        @(posedge clk);
        #1 in_valid = 1'b0;
    endtask
    // Judge the oldest result; flags are drop, mgmt, push, keep
    task automatic rx(input logic [3:0] f, logic [11:0] v, logic [7:0] m, tg);
        logic [159:0] r;
        int n;
        for (n = 0; n < 50 && q.size() == 0; n++) @(posedge clk) #1;
        if (n == 50) n_fail++;
        if (n == 50) close_out();
        r = q.pop_front();
        chk(128'(r[159:156] & (f[3] ? 4'hc : 4'hf)), 128'(f));
        chk(128'(r[143:136]), 128'(m));
        if (!f[3]) begin
            chk(128'(r[155:144]), 128'(v));
            chk(128'(r[135:128] & m), 128'(tg));
            chk(r[127:0], tp_e);
        end
    endtask
    task automatic io(input logic [2:0] p, logic [16:0] tg, logic [11:0] v, logic mg,
        logic [3:0] f, logic [11:0] ev, logic [7:0] m, et);
        tx(p, tg, v, mg);
        rx(f, ev, m, et);
    endtask
    task automatic t_types();
        io(3'h2, 17'h00000, 12'h000, 1'b0, 4'h2, 12'h001, 8'hfb, 8'h00);
        io(3'h0, 17'h18100, 12'h005, 1'b0, 4'h3, 12'h001, 8'hfe, 8'h00);
        io(3'h0, 17'h188a8, 12'h001, 1'b0, 4'h8, 12'h000, 8'h00, 8'h00);
        port(3'h1, PT_CUSTOMER, TX_UNTAG_PVID, 2'h0);
        port(3'h3, PT_SERVICE, TX_UNTAG_PVID, 2'h0);
        port(3'h4, PT_SERVICE_CUSTOM, TX_UNTAG_PVID, 2'h0);
        tp_e[79:48] = 32'h88a8_88a8;
        io(3'h1, 17'h18100, 12'h001, 1'b0, 4'h0, 12'h001, 8'hfd, 8'h00);
        io(3'h1, 17'h19100, 12'h001, 1'b0, 4'h8, 12'h000, 8'h00, 8'h00);
        io(3'h3, 17'h18100, 12'h001, 1'b0, 4'h8, 12'h000, 8'h00, 8'h00);
        cfg_custom_etype = 16'h9100;
        pulse(cfg_glob_we);
        tp_e[79:64] = 16'h9100;
        io(3'h3, 17'h188a8, 12'h001, 1'b0, 4'h0, 12'h001, 8'hf7, 8'h00);
        $display("test port types done");
    endtask
    task automatic t_tags();
        port(3'h5, PT_UNAWARE, TX_TAG_ALL, 2'h2);
        port(3'h6, PT_UNAWARE, TX_UNTAG_ALL, 2'h2);
        {cfg_vlan_vid, cfg_vlan_members} = {12'h007, 8'hff};
        pulse(cfg_vlan_we);
        io(3'h1, 17'h18100, 12'h007, 1'b0, 4'h0, 12'h007, 8'hfd, 8'hbd);
        io(3'h5, 17'h00000, 12'h000, 1'b0, 4'h2, 12'h001, 8'h9f, 8'h00);
        io(3'h0, 17'h00000, 12'h000, 1'b0, 4'h2, 12'h001, 8'hfe, 8'h20);
        $display("test tagging and isolation done");
    endtask
    task automatic t_private();
        port(3'h7, PT_UNAWARE, TX_UNTAG_PVID, 2'h1);
        io(3'h7, 17'h18100, 12'h007, 1'b0, 4'h3, 12'h001, 8'h01, 8'h00);
        {cfg_pvlan_idx, cfg_pvlan_members, cfg_pvlan_uplink} = {3'h1, 8'hff, 3'h2};
        pulse(cfg_pvlan_we);
        io(3'h7, 17'h00000, 12'h000, 1'b0, 4'h2, 12'h001, 8'h04, 8'h00);
        $display("test private done");
    endtask
    task automatic t_members();
        {cfg_vlan_vid, cfg_vlan_members} = {12'h001, 8'hfe};
        pulse(cfg_vlan_we);
        io(3'h2, 17'h00000, 12'h000, 1'b1, 4'h6, 12'h001, 8'hfa, 8'h20);
        io(3'h0, 17'h00000, 12'h000, 1'b1, 4'h8, 12'h000, 8'h00, 8'h00);
        {cfg_vlan_vid, cfg_vlan_members, cfg_mgmt_vid} = {12'h007, 8'h01, 12'h007};
        pulse(cfg_vlan_we);
        pulse(cfg_glob_we);
        io(3'h2, 17'h00000, 12'h000, 1'b1, 4'h2, 12'h001, 8'hfa, 8'h20);
        cfg_pvid = 12'h007;
        cfg_filter_en = 1'b1;
        port(3'h0, PT_CUSTOMER, TX_UNTAG_PVID, 2'h0);
        io(3'h0, 17'h00000, 12'h000, 1'b1, 4'h6, 12'h007, 8'h00, 8'h00);
        io(3'h0, 17'h18100, 12'h001, 1'b0, 4'h8, 12'h000, 8'h00, 8'h00);
        $display("test membership done");
    endtask
    task automatic t_stall();
        stall = 1'b1;
        tx(3'h2, 17'h00000, 12'h000, 1'b0);
        tx(3'h3, 17'h00000, 12'h000, 1'b0);
        chk(128'(in_ready), 128'h0);
        stall = 1'b0;
        tx(3'h4, 17'h00000, 12'h000, 1'b0);
        rx(4'h2, 12'h001, 8'hfa, 8'h20);
        rx(4'h2, 12'h001, 8'hf6, 8'h20);
        rx(4'h2, 12'h001, 8'hee, 8'h20);
        $display("test stall done");
    endtask
    initial begin
        {rst_n, stall, cfg_port_we, cfg_glob_we, cfg_vlan_we, cfg_pvlan_we} = 6'h00;
        {in_valid, cfg_filter_en, cfg_isolate_en, cfg_private_en, in_tagged, in_mgmt} = 6'h00;
        {cfg_port_idx, cfg_pvlan_idx, cfg_pvlan_uplink, in_port} = 12'h000;
        cfg_port_type = PT_UNAWARE;
        cfg_tx_mode = TX_UNTAG_PVID;
        {cfg_pvid, cfg_mgmt_vid, cfg_vlan_vid, in_vid} = 48'h001_001_001_000;
        {cfg_custom_etype, in_tag_protocol_identifier} = 32'h0;
        {cfg_vlan_members, cfg_pvlan_members} = 16'h0;
        tp_e = {8{16'h8100}};
        {n_fail, samples_checked} = 64'h0;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        t_types();
        t_tags();
        t_private();
        t_members();
        t_stall();
        close_out();
    end
endmodule // tb_top
